// >>> sdh_defines.svh
// Register addresses, field positions and fixed codes for the SDRAM setup host
`ifndef SDH_DEFINES_SVH
`define SDH_DEFINES_SVH

// Device register byte addresses
`define SDH_ADDR_MEMCFG 32'h0a000304
`define SDH_ADDR_MODE 32'h0a000308
`define SDH_ADDR_TIMING 32'h0a00030c

// Memory configuration register fields
`define SDH_CFG_INIT_BIT 15
`define SDH_CFG_SDRAM_SEL 16'h0001
`define SDH_CFG_B1_LSB 10
`define SDH_CFG_B0_LSB 1
`define SDH_BANK_16M 2'h1
`define SDH_BANK_64M 2'h2

// Mode value fields
`define SDH_MODE_CAS_LSB 4
`define SDH_CAS_2CLK 3'h2
`define SDH_CAS_3CLK 3'h3
`define SDH_BURST_FULL_PAGE 3'h7
`define SDH_MODE_RSVD_MASK 16'hf000

// Timing register fields
`define SDH_TIM_FIXED_PAT 2'h1
`define SDH_TIM_RSVD_MASK 16'hfc00
`define SDH_TIM_RAS_LSB 6
`define SDH_TIM_RC_LSB 4
`define SDH_TIM_RP_LSB 2
`define SDH_TIM_RCD_LSB 0

// Reset value of all three device registers
`define SDH_REG_RESET 16'h0000

// Error codes
`define SDH_ERR_NONE 2'h0
`define SDH_ERR_BAD_CODE 2'h1
`define SDH_ERR_TIMEOUT 2'h2
`define SDH_ERR_READBACK 2'h3

// Default poll limit for the init bit
`define SDH_POLL_LIMIT 1024

`endif

// >>> sdh_pkg.sv
// Types shared by the SDRAM setup host
package sdh_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_TIMING,
        ST_CFG_PRE,
        ST_MODE,
        ST_INIT,
        ST_POLL,
        ST_CFG_FINAL,
        ST_CHK_MODE,
        ST_CHK_TIMING
    } sdh_state_t;

endpackage

// >>> sdh_link.sv
// Link-clock side: performs one register access per request toggle
`timescale 1ns/100ps
`include "sdh_defines.svh"

module sdh_link
    import sdh_pkg::*;
(
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic req_tgl,
    input wire logic op_write,
    input wire logic [31:0] op_addr,
    input wire logic [15:0] op_wdata,
    output logic ack_tgl,
    output logic [15:0] rd_data,
    output logic [31:0] dev_addr,
    output logic [15:0] dev_wdata,
    output logic dev_we,
    output logic dev_re,
    input wire logic [15:0] dev_rdata
);

    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic rd_wait;
    logic next_ack_tgl;
    logic [15:0] next_rd_data;
    logic [31:0] next_dev_addr;
    logic [15:0] next_dev_wdata;
    logic next_dev_we;
    logic next_dev_re;
    logic next_rd_wait;

    // Request toggle synchroniser; the edge is taken from stages two and three
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end
        else
        begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    // One-cycle strobe; a read captures data on the following cycle
    always_comb
    begin
        next_ack_tgl = ack_tgl;
        next_rd_data = rd_data;
        next_dev_addr = dev_addr;
        next_dev_wdata = dev_wdata;
        next_dev_we = 1'b0;
        next_dev_re = 1'b0;
        next_rd_wait = 1'b0;
        if (rd_wait)
        begin
            next_rd_data = dev_rdata;
            next_ack_tgl = ~ack_tgl;
        end
        else if (req_s2 != req_s3)
        begin
            next_dev_addr = op_addr;
            next_dev_wdata = op_write ? op_wdata : 16'h0000;
            next_dev_we = op_write;
            next_dev_re = ~op_write;
            next_rd_wait = ~op_write;
            if (op_write)
            begin
                next_ack_tgl = ~ack_tgl;
            end
        end
    end

    // Link-side registers
    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_tgl <= 1'b0;
            rd_data <= 16'h0000;
            dev_addr <= 32'h00000000;
            dev_wdata <= 16'h0000;
            dev_we <= 1'b0;
            dev_re <= 1'b0;
            rd_wait <= 1'b0;
        end
        else
        begin
            ack_tgl <= next_ack_tgl;
            rd_data <= next_rd_data;
            dev_addr <= next_dev_addr;
            dev_wdata <= next_dev_wdata;
            dev_we <= next_dev_we;
            dev_re <= next_dev_re;
            rd_wait <= next_rd_wait;
        end
    end

endmodule

// >>> sdh_host.sv
// Host controller that programs and starts the SDRAM mode and timing setup
//
// What this block does
// - Mode value bits 11 and 10 are always written as zero.
// - Burst-read single-write bit 9 is always written as zero.
// - Test and vendor bits 8 and 7 are always written as zero.
// - CAS latency code 010 is two clocks, 011 three; others refused.
// - Burst wrap type bit 3 is always written zero, sequential order.
// - Burst length bits 2..0 always written 111, full page.
// - Mode value is written before the init trigger is set.
// - Timing bits 9 and 8 hold 01 before any SDRAM use.
// - Timing bit 8 resets to zero, so it is written to one.
// - Timing register is loaded before any SDRAM access.
`timescale 1ns/100ps
`include "sdh_defines.svh"

module sdh_host
    import sdh_pkg::*;
#(
    parameter int POLL_LIMIT = `SDH_POLL_LIMIT
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic start,
    input wire logic [2:0] cas_latency_code,
    input wire logic [7:0] timing_codes,
    input wire logic [1:0] bank0_cfg,
    input wire logic [1:0] bank1_cfg,
    output logic busy,
    output logic done,
    output logic [1:0] err_code,
    output logic [31:0] dev_addr,
    output logic [15:0] dev_wdata,
    output logic dev_we,
    output logic dev_re,
    input wire logic [15:0] dev_rdata
);

    initial
    begin
        if (POLL_LIMIT < 1 || POLL_LIMIT > 65535)
            $error("POLL_LIMIT out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Legal timing field codes for the device
    function automatic logic timing_ok(input logic [7:0] t);
        return t[7:6] <= 2'h1 && t[5:4] <= 2'h1 && !t[2] && t[1:0] <= 2'h1;
    endfunction

    // Memory configuration word with chosen bank codes and init bit
    function automatic logic [15:0] cfg_word(input logic [1:0] b0,
                                             input logic [1:0] b1,
                                             input logic init);
        logic [15:0] w;
        w = `SDH_CFG_SDRAM_SEL;
        w[`SDH_CFG_B0_LSB +: 2] = b0;
        w[`SDH_CFG_B1_LSB +: 2] = b1;
        w[`SDH_CFG_INIT_BIT] = init;
        return w;
    endfunction

    // Pre-init bank code: a 64 Mbit bank is first set as 16 Mbit
    function automatic logic [1:0] pre_bank(input logic [1:0] b);
        return (b == `SDH_BANK_64M) ? `SDH_BANK_16M : b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Crossing to the link side

    logic req_tgl;
    logic op_write;
    logic [31:0] op_addr;
    logic [15:0] op_wdata;
    logic ack_tgl;
    logic [15:0] rd_data;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic ack_seen;

    sdh_link u_link (
        .link_clk(link_clk),
        .rstn(rstn),
        .req_tgl(req_tgl),
        .op_write(op_write),
        .op_addr(op_addr),
        .op_wdata(op_wdata),
        .ack_tgl(ack_tgl),
        .rd_data(rd_data),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_we(dev_we),
        .dev_re(dev_re),
        .dev_rdata(dev_rdata)
    );

    // Acknowledge toggle synchroniser
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end
        else
        begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    assign ack_seen = ack_s2 != ack_s3;

    ////////////////////////////////////////////////////////////////////////
    // Setup sequencer

    sdh_state_t state;
    sdh_state_t next_state;
    logic inflight;
    logic next_inflight;
    logic [15:0] mode_val;
    logic [15:0] next_mode_val;
    logic [15:0] tim_val;
    logic [15:0] next_tim_val;
    logic [1:0] b0;
    logic [1:0] next_b0;
    logic [1:0] b1;
    logic [1:0] next_b1;
    logic [15:0] poll_cnt;
    logic [15:0] next_poll_cnt;
    logic next_req_tgl;
    logic next_op_write;
    logic [31:0] next_op_addr;
    logic [15:0] next_op_wdata;
    logic next_busy;
    logic next_done;
    logic [1:0] next_err_code;
    logic cas_ok;

    // only the two defined latency codes are accepted
    assign cas_ok = (cas_latency_code == `SDH_CAS_2CLK) ||
                    (cas_latency_code == `SDH_CAS_3CLK);

    // Next values of the sequencer
    always_comb
    begin
        next_state = state;
        next_inflight = inflight;
        next_mode_val = mode_val;
        next_tim_val = tim_val;
        next_b0 = b0;
        next_b1 = b1;
        next_poll_cnt = poll_cnt;
        next_req_tgl = req_tgl;
        next_op_write = op_write;
        next_op_addr = op_addr;
        next_op_wdata = op_wdata;
        next_busy = busy;
        next_done = done;
        next_err_code = err_code;
        if (state == ST_IDLE)
        begin
            if (start)
            begin
                next_done = 1'b0;
                next_mode_val = {9'h000, cas_latency_code, 1'b0,
                                 `SDH_BURST_FULL_PAGE};
                // fixed pattern 01 in bits 9..8
                next_tim_val = {6'h00, `SDH_TIM_FIXED_PAT, timing_codes};
                next_b0 = bank0_cfg;
                next_b1 = bank1_cfg;
                next_poll_cnt = 16'h0000;
                if (!cas_ok || !timing_ok(timing_codes))
                begin
                    next_err_code = `SDH_ERR_BAD_CODE;
                    next_done = 1'b1;
                end
                else
                begin
                    next_err_code = `SDH_ERR_NONE;
                    next_busy = 1'b1;
                    next_state = ST_TIMING;
                end
            end
        end
        else if (!inflight)
        begin
            // Launch the access that belongs to this step
            next_inflight = 1'b1;
            next_req_tgl = ~req_tgl;
            next_op_write = !(state inside {ST_POLL, ST_CHK_MODE,
                                            ST_CHK_TIMING});
            // 64 Mbit banks set as 16 Mbit until the final write
            // init set only in the step after the mode write
            next_op_wdata = cfg_word(pre_bank(b0), pre_bank(b1),
                                     state == ST_INIT);
            if (state == ST_CFG_FINAL)
                next_op_wdata = cfg_word(b0, b1, 1'b0);
            case (state)
                ST_TIMING:
                begin
                    next_op_addr = `SDH_ADDR_TIMING;
                    next_op_wdata = tim_val;
                end
                ST_MODE:
                begin
                    next_op_addr = `SDH_ADDR_MODE;
                    next_op_wdata = mode_val;
                end
                ST_CHK_MODE:
                    next_op_addr = `SDH_ADDR_MODE;
                ST_CHK_TIMING:
                    next_op_addr = `SDH_ADDR_TIMING;
                default:
                    next_op_addr = `SDH_ADDR_MEMCFG;
            endcase
        end
        else if (ack_seen)
        begin
            // Access finished; pick the following step
            next_inflight = 1'b0;
            case (state)
                ST_TIMING:
                    next_state = ST_CFG_PRE;
                ST_CFG_PRE:
                    next_state = ST_MODE;
                ST_MODE:
                    next_state = ST_INIT;
                ST_INIT:
                    next_state = ST_POLL;
                ST_POLL:
                begin
                    // wait for hardware to clear the init bit
                    if (!rd_data[`SDH_CFG_INIT_BIT])
                        next_state = ST_CFG_FINAL;
                    else if (poll_cnt == 16'(POLL_LIMIT - 1))
                    begin
                        next_err_code = `SDH_ERR_TIMEOUT;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                        next_state = ST_IDLE;
                    end
                    else
                        next_poll_cnt = poll_cnt + 16'h0001;
                end
                ST_CFG_FINAL:
                    next_state = ST_CHK_MODE;
                ST_CHK_MODE:
                begin
                    if (rd_data != mode_val ||
                        (rd_data & `SDH_MODE_RSVD_MASK) != 16'h0000)
                        next_err_code = `SDH_ERR_READBACK;
                    next_state = ST_CHK_TIMING;
                end
                ST_CHK_TIMING:
                begin
                    if (rd_data != tim_val ||
                        (rd_data & `SDH_TIM_RSVD_MASK) != 16'h0000)
                        next_err_code = `SDH_ERR_READBACK;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
                default:
                    next_state = ST_IDLE;
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            inflight <= 1'b0;
            mode_val <= `SDH_REG_RESET;
            tim_val <= `SDH_REG_RESET;
            b0 <= 2'h0;
            b1 <= 2'h0;
            poll_cnt <= 16'h0000;
            req_tgl <= 1'b0;
            op_write <= 1'b0;
            op_addr <= 32'h00000000;
            op_wdata <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
            err_code <= `SDH_ERR_NONE;
        end
        else
        begin
            state <= next_state;
            inflight <= next_inflight;
            mode_val <= next_mode_val;
            tim_val <= next_tim_val;
            b0 <= next_b0;
            b1 <= next_b1;
            poll_cnt <= next_poll_cnt;
            req_tgl <= next_req_tgl;
            op_write <= next_op_write;
            op_addr <= next_op_addr;
            op_wdata <= next_op_wdata;
            busy <= next_busy;
            done <= next_done;
            err_code <= next_err_code;
        end
    end

endmodule

// >>> sdh_host_sva.sv
// Port checker for the SDRAM setup host
`timescale 1ns/100ps
`include "sdh_defines.svh"

module sdh_host_chk
    import sdh_pkg::*;
#(
    parameter int POLL_LIMIT = `SDH_POLL_LIMIT
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic start,
    input wire logic [2:0] cas_latency_code,
    input wire logic [7:0] timing_codes,
    input wire logic [1:0] bank0_cfg,
    input wire logic [1:0] bank1_cfg,
    input wire logic busy,
    input wire logic done,
    input wire logic [1:0] err_code,
    input wire logic [31:0] dev_addr,
    input wire logic [15:0] dev_wdata,
    input wire logic dev_we,
    input wire logic dev_re,
    input wire logic [15:0] dev_rdata
);

logic mode_wr;
logic init_wr;
logic mode_seen;

// Writes seen on the device pins
assign mode_wr = dev_we && dev_addr == `SDH_ADDR_MODE;
assign init_wr = dev_we && dev_addr == `SDH_ADDR_MEMCFG && dev_wdata[15];

// Mode written since the timing write that opens a run
always_ff @(posedge link_clk or negedge rstn)
begin
    if (!rstn)
        mode_seen <= 1'b0;
    else if (dev_we && dev_addr == `SDH_ADDR_TIMING)
        mode_seen <= 1'b0;
    else if (mode_wr)
        mode_seen <= 1'b1;
end

////////////////////////////////////////
a_mode_zero_bits:
    assert property (@(posedge link_clk) disable iff (!rstn)
        mode_wr |-> dev_wdata[15:7] == 9'h000) else $error("mode high bits");
a_cas_code_legal:
    assert property (@(posedge link_clk) disable iff (!rstn)
        mode_wr |-> dev_wdata[6:4] inside {`SDH_CAS_2CLK, `SDH_CAS_3CLK})
        else $error("cas code");
a_wrap_full_page:
    assert property (@(posedge link_clk) disable iff (!rstn)
        mode_wr |-> dev_wdata[3:0] == 4'h7) else $error("burst code");
a_timing_fixed_bits:
    assert property (@(posedge link_clk) disable iff (!rstn)
        dev_we && dev_addr == `SDH_ADDR_TIMING |-> dev_wdata[15:8] == 8'h01)
        else $error("timing bits 15:8");
a_mode_before_init:
    assert property (@(posedge link_clk) disable iff (!rstn)
        init_wr |-> mode_seen) else $error("init before mode");
a_init_bank_16m:
    assert property (@(posedge link_clk) disable iff (!rstn)
        init_wr |-> dev_wdata[11:10] != 2'h2 && dev_wdata[2:1] != 2'h2)
        else $error("init with 64M code");
a_bad_code_refused:
    assert property (@(posedge clk) disable iff (!rstn)
        start && !busy && !(cas_latency_code inside {3'h2, 3'h3})
        |=> done && !busy && err_code == `SDH_ERR_BAD_CODE)
        else $error("bad code accepted");
a_run_end_done:
    assert property (@(posedge clk) disable iff (!rstn)
        $fell(busy) |-> done && !$past(done)) else $error("no done");

endmodule

bind sdh_host sdh_host_chk #(.POLL_LIMIT(POLL_LIMIT)) u_chk (.clk, .rstn,
    .link_clk, .start, .cas_latency_code, .timing_codes, .bank0_cfg,
    .bank1_cfg, .busy, .done, .err_code, .dev_addr, .dev_wdata, .dev_we,
    .dev_re, .dev_rdata);

// >>> sdh_dev_model.sv
// Behavioural SDRAM controller registers behind the access pins
`timescale 1ns/100ps
`include "sdh_defines.svh"

module sdh_dev_model
#(
    parameter int INIT_CYC = 3
)
(
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic [31:0] dev_addr,
    input wire logic [15:0] dev_wdata,
    input wire logic dev_we,
    input wire logic dev_re,
    output logic [15:0] dev_rdata,
    input wire logic stuck_init,
    input wire logic bad_read
);

logic [15:0] mem_cfg;
logic [15:0] mode_val;
logic [15:0] timing;
logic [13:0] mode_pins;
logic [3:0] init_cnt;
logic [15:0] rd_val;
logic [15:0] rd_last;
logic [3:0] init_wait;
logic a13;

// Read mux; the mode read can be spoiled on command
assign rd_val = dev_addr == `SDH_ADDR_MEMCFG ? mem_cfg :
    dev_addr == `SDH_ADDR_MODE ? mode_val ^ {15'h0, bad_read} :
    dev_addr == `SDH_ADDR_TIMING ? timing : 16'h0000;
assign a13 = mem_cfg[11:10] == 2'h2 || mem_cfg[2:1] == 2'h2;
// Read data stands while the strobe is high; idle lines show the inverse
assign dev_rdata = dev_re ? rd_val : ~rd_last;
// mode set also waits out the programmed precharge
assign init_wait = 4'(INIT_CYC) + (timing[3] ? 4'h3 : 4'h1);

////////////////////////////////////////
// Writes, mode set and the last word shown on the data lines
always_ff @(posedge link_clk or negedge rstn)
begin
    if (!rstn)
    begin
        mem_cfg <= `SDH_REG_RESET;
        mode_val <= `SDH_REG_RESET;
        timing <= `SDH_REG_RESET;
        mode_pins <= 14'h0000;
        init_cnt <= 4'h0;
        rd_last <= 16'h0000;
    end
    else
    begin
        rd_last <= dev_rdata;
        init_cnt <= mem_cfg[15] ? init_cnt + 4'h1 : 4'h0;
        if (dev_we && dev_addr == `SDH_ADDR_MEMCFG)
            mem_cfg <= dev_wdata & 16'h8dc7;
        if (dev_we && dev_addr == `SDH_ADDR_MODE)
            mode_val <= dev_wdata & 16'h0fff;
        if (dev_we && dev_addr == `SDH_ADDR_TIMING)
            timing <= dev_wdata & 16'h03ff;
        if (init_cnt == init_wait && !stuck_init && !dev_we)
        begin
            mode_pins <= {a13, mode_val[12:0]};
            mem_cfg[15] <= 1'b0;
        end
    end
end

endmodule

// >>> tb_sdram_mode_and_timing_config.sv
// Self-checking bench for the SDRAM setup host and a device model
`timescale 1ns/100ps
`include "sdh_defines.svh"

module tb_sdram_mode_and_timing_config
    import sdh_pkg::*;
;

typedef struct {
    logic [1:0] err;
    logic regs;
    logic [15:0] mode;
    logic [15:0] tim;
    logic [15:0] cfg;
} sdh_note_t;

logic clk = 1'b0;
logic link_clk;
logic rstn;
logic start;
logic [2:0] cas_latency_code;
logic [7:0] timing_codes;
logic [1:0] bank0_cfg;
logic [1:0] bank1_cfg;
logic busy;
logic done;
logic [1:0] err_code;
logic [31:0] dev_addr;
logic [15:0] dev_wdata;
logic dev_we;
logic dev_re;
logic [15:0] dev_rdata;
logic stuck_init;
logic bad_read;
logic armed;
sdh_note_t notes[$];
sdh_note_t got;
int fails;
int tests_run;
int i;
logic [7:0] bad_tc [4] = '{8'hc0, 8'h20, 8'h04, 8'h03};

sdh_host #(.POLL_LIMIT(4)) uut (.clk, .rstn, .link_clk, .start,
    .cas_latency_code, .timing_codes, .bank0_cfg, .bank1_cfg, .busy, .done,
    .err_code, .dev_addr, .dev_wdata, .dev_we, .dev_re, .dev_rdata);
sdh_dev_model #(.INIT_CYC(3)) dev (.link_clk, .rstn, .dev_addr, .dev_wdata,
    .dev_we, .dev_re, .dev_rdata, .stuck_init, .bad_read);

// Clocks of unrelated phase
always #2.5 clk = ~clk;
initial
begin
    link_clk = 1'b0;
    #37.3;
    forever #80 link_clk = ~link_clk;
end

task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
        fails++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
endtask

task print_verdict();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask

// One setup run: note the expectation, start, wait for done
task automatic run(input logic [2:0] cas, input logic [7:0] tc,
    input logic [1:0] b0, input logic [1:0] b1, input logic [1:0] err,
    input bit poke);
    sdh_note_t n;
    int k;
    n.err = err;
    n.regs = err == 2'h0;
    n.mode = {9'h000, cas, 4'h7};
    n.tim = {8'h01, tc};
    n.cfg = {4'h0, b1, 7'h00, b0, 1'b1};
    @(posedge clk);
    start <= 1'b1;
    cas_latency_code <= cas;
    timing_codes <= tc;
    bank0_cfg <= b0;
    bank1_cfg <= b1;
    notes.push_back(n);
    @(posedge clk);
    start <= 1'b0;
    if (poke)
    begin
        repeat (30) @(posedge clk);
        start <= 1'b1;
        cas_latency_code <= 3'h5;
        @(posedge clk);
        start <= 1'b0;
    end
    k = 0;
    @(negedge clk);
    while (done !== 1'b1 && k < 20000)
    begin
        @(negedge clk);
        k++;
    end
    if (k >= 20000)
        check(16'h0001, 16'h0000);
endtask

////////////////////////////////////////
// Compares each result with the oldest note
always @(negedge clk)
begin
    if (rstn !== 1'b1)
        armed = 1'b0;
    else if (armed && done === 1'b1)
    begin
        armed = 1'b0;
        if (notes.size() == 0)
            check(16'h0001, 16'h0000);
        else
        begin
            got = notes.pop_front();
            check({14'h0, err_code}, {14'h0, got.err});
            if (got.regs)
            begin
                check(dev.mode_val, got.mode);
                check(dev.timing, got.tim);
                check(dev.mem_cfg, got.cfg);
                check({2'h0, dev.mode_pins}, got.mode);
            end
        end
    end
    if (rstn === 1'b1 && start === 1'b1 && busy === 1'b0)
        armed = 1'b1;
end

// Watchdog
initial
begin
    #400000;
    check(16'h0001, 16'h0000);
    print_verdict();
end

////////////////////////////////////////
// Main sequence
initial
begin
    rstn = 1'b0;
    start = 1'b0;
    cas_latency_code = 3'h0;
    timing_codes = 8'h00;
    bank0_cfg = 2'h0;
    bank1_cfg = 2'h0;
    stuck_init = 1'b0;
    bad_read = 1'b0;
    armed = 1'b0;
    fails = 0;
    tests_run = 0;
    void'($urandom(85));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(dev.timing, `SDH_REG_RESET);
    check(dev.mode_val, `SDH_REG_RESET);
    run(3'h2, 8'h00, 2'h1, 2'h0, 2'h0, 1'b0);
    run(3'h3, 8'h59, 2'h2, 2'h2, 2'h0, 1'b1);
    // Every CAS code with random legal timing and banks
    for (i = 0; i < 8; i++)
        run(i[2:0], {1'b0, 1'($urandom), 1'b0, 1'($urandom), 1'($urandom),
            2'h0, 1'($urandom)}, 2'($urandom % 3), 2'($urandom % 3),
            (i == 2 || i == 3) ? 2'h0 : 2'h1, 1'b0);
    for (i = 0; i < 4; i++)
        run(3'h3, bad_tc[i], 2'h1, 2'h1, 2'h1, 1'b0);
    @(posedge clk);
    stuck_init <= 1'b1;
    run(3'h2, 8'h00, 2'h1, 2'h1, 2'h2, 1'b0);
    stuck_init <= 1'b0;
    @(posedge clk);
    bad_read <= 1'b1;
    run(3'h3, 8'h19, 2'h1, 2'h2, 2'h3, 1'b0);
    bad_read <= 1'b0;
    // Reset in mid-run
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (400) @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check({10'h000, busy, done, err_code, dev_we, dev_re}, 16'h0000);
    repeat (70) @(posedge clk);
    rstn <= 1'b1;
    run(3'h2, 8'h59, 2'h2, 2'h1, 2'h0, 1'b0);
    print_verdict();
end

endmodule
